// [logic/fault_locator_trigger.v]
// Overview of operation
// R1: Use fundamental magnitudes on 5 ms steps
// R2: Trigger selected from any internal binary signal
// R3: On trigger, check blocking first
// R4: Sample block input each processing cycle start
// R5: Blocked pick-up raises indication, stops processing
// R6: Source asserts block 5 ms early
// R7: No earth voltages: phase-phase loops only
// R8: Earth voltages allow phase-neutral loops too
// R9: Two or three phases choose phase-phase loop
// R10: Single phase: neutral loop only with voltages
// R11: No current over threshold: no record
// R12: Threshold configurable, default one times nominal
// R13: Line_a configurable, default 0.125
// R14: Setting group changes apply while running
// R15: ON/OFF events for triggered and calculation
// R16: Per-event mask; events time stamped
// R17: Cumulative trigger count, clearable
// R18: Keep last twelve records, overwrite oldest
// R19: Record holds stamp, type, direction, values, group; no direction is stored, rec_dir is always DIR_NONE
// R20: Distance is reactance over line_a
// R21: Trigger acts on rising edge only
`timescale 1ns/1ps
`include "fault_locator_map.vh"
module fault_locator_trigger #(
  parameter integer CYCLE_CLKS = `CYCLE_NS / `CLK_NS // Clocks per 5 ms cycle
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Binary signals and selection
  input wire [31:0] binary_signals,
  input wire [4:0] trigger_select,
  input wire block_in,
  // Fundamental magnitudes, 0.1 x In units for currents
  input wire [`MAG_W-1:0] phase_a_current,
  input wire [`MAG_W-1:0] phase_b_current,
  input wire [`MAG_W-1:0] phase_c_current,
  input wire earth_voltage_valid,
  input wire [`MAG_W-1:0] nominal_primary_amps,
  // Loop reactances, milliohm
  input wire [`REACT_W-1:0] loop_ab_reactance,
  input wire [`REACT_W-1:0] loop_bc_reactance,
  input wire [`REACT_W-1:0] loop_ca_reactance,
  input wire [`REACT_W-1:0] loop_a_neutral_reactance,
  input wire [`REACT_W-1:0] loop_b_neutral_reactance,
  input wire [`REACT_W-1:0] loop_c_neutral_reactance,
  // Setting groups
  input wire [2:0] active_group,
  input wire [8*`MAG_W-1:0] trigger_current_set,
  input wire [8*`REACT_W-1:0] line_a_set,
  input wire [1:0] mask_triggered,
  input wire [1:0] mask_calc,
  // Time base
  input wire [`TS_W-1:0] time_stamp,
  // Counter control
  input wire count_clear,
  // Status
  output reg cycle_tick,
  output reg blocked,
  output reg triggered,
  output reg calc_active,
  output reg [15:0] trigger_count,
  // Event stream
  output reg event_valid,
  output reg [1:0] event_code,
  output reg [`TS_W-1:0] event_time,
  // Record readout
  input wire [3:0] rec_index,
  output reg [3:0] rec_count,
  output reg [`TS_W-1:0] rec_time,
  output reg [1:0] rec_event,
  output reg [2:0] rec_type,
  output reg [1:0] rec_dir,
  output reg [`REACT_W-1:0] rec_react,
  output reg [`MAG_W-1:0] rec_cur_pu,
  output reg [31:0] rec_cur_pri,
  output reg [`DIST_W-1:0] rec_dist,
  output reg [2:0] rec_group
);
  // ****************************************
  // Timing
  // ****************************************
  localparam [19:0] CYCLE_LAST = CYCLE_CLKS[19:0] - 20'h00001;
  // One-hot states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_EVAL = 4'h2;
  localparam [3:0] ST_CALC = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;
  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [33:0] sync1;
  reg [33:0] sync2;
  reg [19:0] cyc_cnt;
  reg trig_prev;
  reg block_sampled;
  reg [3:0] state;
  reg [2:0] fault_type;
  reg [`REACT_W-1:0] sel_react;
  reg [`MAG_W-1:0] sel_cur;
  reg div_start;
  reg [`TS_W-1:0] trig_time;
  reg [3:0] wr_ptr;
  reg [2:0] next_type;
  reg [`REACT_W-1:0] next_react;
  reg [`MAG_W-1:0] next_cur;
  wire trig_now;
  wire [`MAG_W-1:0] thr;
  wire [`REACT_W-1:0] per_km;
  wire div_done;
  wire [`DIST_W-1:0] div_q;
  wire [2:0] over;
  // Pins cross in through two flops; the first stage feeds only the second
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 34'h000000000;
      sync2 <= 34'h000000000;
    end else begin
      sync1 <= {earth_voltage_valid, block_in, binary_signals};
      sync2 <= sync1;
    end
  end
  assign trig_now = sync2[trigger_select]; // R2
  // Active group picks the settings live, no restart needed
  assign thr = trigger_current_set[active_group*`MAG_W +: `MAG_W]; // R12 R14
  assign per_km = line_a_set[active_group*`REACT_W +: `REACT_W]; // R13 R14
  // Comparator reused for all three phases
  function over_thr;
    input [`MAG_W-1:0] mag;
    input [`MAG_W-1:0] limit;
    begin
      over_thr = (mag > limit);
    end
  endfunction
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_cmp
      wire [`MAG_W-1:0] m;
      assign m = (g == 0) ? phase_a_current : (g == 1) ? phase_b_current : phase_c_current;
      assign over[g] = over_thr(m, thr);
    end
  endgenerate
  // ****************************************
  // Processing cycle tick
  // ****************************************
  // Trigger and block decisions are taken on the 5 ms tick, like the measurement refresh; count_clear acts on any clock but the ST_EVAL one of an unblocked pass
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_cnt <= 20'h00000;
      cycle_tick <= 1'b0;
      block_sampled <= 1'b0;
    end else begin
      cycle_tick <= (cyc_cnt == CYCLE_LAST); // R1
      if (cyc_cnt == CYCLE_LAST) begin
        cyc_cnt <= 20'h00000;
        block_sampled <= sync2[`SYNC_BLOCK]; // R4 R6
      end else begin
        cyc_cnt <= cyc_cnt + 20'h00001;
      end
    end
  end
  // ****************************************
  // Loop selection
  // ****************************************
  // Table of loops; single phase only counts when earth voltages exist
  always @* begin
    next_type = `FT_NONE;
    next_react = 16'h0000;
    next_cur = 16'h0000;
    case (over)
      3'h7: begin
        next_type = `FT_ABC; // R9
        next_react = loop_ab_reactance;
        next_cur = phase_a_current;
      end
      3'h3: begin
        next_type = `FT_AB; // R9 R7
        next_react = loop_ab_reactance;
        next_cur = phase_a_current;
      end
      3'h6: begin
        next_type = `FT_BC; // R9
        next_react = loop_bc_reactance;
        next_cur = phase_b_current;
      end
      3'h5: begin
        next_type = `FT_CA; // R9
        next_react = loop_ca_reactance;
        next_cur = phase_c_current;
      end
      3'h1: begin
        next_type = sync2[`SYNC_EARTH] ? `FT_AN : `FT_NONE; // R10 R8
        next_react = loop_a_neutral_reactance;
        next_cur = phase_a_current;
      end
      3'h2: begin
        next_type = sync2[`SYNC_EARTH] ? `FT_BN : `FT_NONE; // R10 R8
        next_react = loop_b_neutral_reactance;
        next_cur = phase_b_current;
      end
      3'h4: begin
        next_type = sync2[`SYNC_EARTH] ? `FT_CN : `FT_NONE; // R10 R8
        next_react = loop_c_neutral_reactance;
        next_cur = phase_c_current;
      end
      default: next_type = `FT_NONE; // R11
    endcase
  end
  distance_divider u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(div_start),
    .num(sel_react),
    .den(per_km),
    .busy(),
    .done(div_done),
    .quotient(div_q)
  );
  // ****************************************
  // Record store
  // ****************************************
  reg [`TS_W-1:0] mem_time [0:`REC_DEPTH-1];
  reg [2:0] mem_type [0:`REC_DEPTH-1];
  reg [`REACT_W-1:0] mem_react [0:`REC_DEPTH-1];
  reg [`MAG_W-1:0] mem_cur [0:`REC_DEPTH-1];
  reg [`DIST_W-1:0] mem_dist [0:`REC_DEPTH-1];
  reg [2:0] mem_group [0:`REC_DEPTH-1];
  wire rec_write;
  assign rec_write = (state == ST_CALC) && div_done;
  // Ring of twelve; the pointer wraps so the oldest entry goes first
  always @(posedge sys_clk) begin
    if (rec_write) begin
      mem_time[wr_ptr] <= trig_time; // R18 R19
      mem_type[wr_ptr] <= fault_type;
      mem_react[wr_ptr] <= sel_react;
      mem_cur[wr_ptr] <= sel_cur;
      mem_dist[wr_ptr] <= div_q;
      mem_group[wr_ptr] <= active_group;
    end
  end
  // Readout registered; index 0 is the oldest kept entry
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_time <= 32'h00000000;
      rec_event <= `EV_CALC_ON;
      rec_type <= `FT_NONE;
      rec_dir <= `DIR_NONE;
      rec_react <= 16'h0000;
      rec_cur_pu <= 16'h0000;
      rec_cur_pri <= 32'h00000000;
      rec_dist <= 16'h0000;
      rec_group <= 3'h0;
    end else if (rec_index < rec_count) begin
      rec_time <= mem_time[phys_index(rec_index)];
      rec_event <= `EV_CALC_ON;
      rec_type <= mem_type[phys_index(rec_index)];
      rec_dir <= `DIR_NONE; // Direction is not measured here
      rec_react <= mem_react[phys_index(rec_index)];
      rec_cur_pu <= mem_cur[phys_index(rec_index)];
      rec_cur_pri <= mem_cur[phys_index(rec_index)] * nominal_primary_amps;
      rec_dist <= mem_dist[phys_index(rec_index)]; // R20
      rec_group <= mem_group[phys_index(rec_index)];
    end
  end
  // Map a logical age index onto the ring
  function [3:0] phys_index;
    input [3:0] idx;
    reg [4:0] sum;
    begin
      sum = (rec_count == `REC_DEPTH) ? {1'b0, wr_ptr} + {1'b0, idx} : {1'b0, idx};
      phys_index = (sum >= `REC_DEPTH) ? sum[3:0] - (`REC_LAST + 4'h1) : sum[3:0];
    end
  endfunction
  // ****************************************
  // Control sequence
  // ****************************************
  // Edge on the selected trigger, seen at a cycle boundary, starts one pass
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      trig_prev <= 1'b0;
      blocked <= 1'b0;
      triggered <= 1'b0;
      calc_active <= 1'b0;
      trigger_count <= 16'h0000;
      fault_type <= `FT_NONE;
      sel_react <= 16'h0000;
      sel_cur <= 16'h0000;
      div_start <= 1'b0;
      trig_time <= 32'h00000000;
      wr_ptr <= 4'h0;
      rec_count <= 4'h0;
      event_valid <= 1'b0;
      event_code <= `EV_TRIG_ON;
      event_time <= 32'h00000000;
    end else begin
      div_start <= 1'b0;
      event_valid <= 1'b0;
      // Clear yields to a same-cycle trigger increment
      if (count_clear && !(state == ST_EVAL && !block_sampled)) begin
        trigger_count <= 16'h0000; // R17
      end
      case (state)
        ST_IDLE: begin
          if (cycle_tick) begin
            trig_prev <= trig_now;
            if (trig_now && !trig_prev) begin
              state <= ST_EVAL; // R21 R3
              trig_time <= time_stamp;
            end else if (!trig_now && triggered) begin
              triggered <= 1'b0;
              event_valid <= mask_triggered[`MASK_OFF]; // R15 R16
              event_code <= `EV_TRIG_OFF;
              event_time <= time_stamp;
            end
            if (!trig_now) begin
              blocked <= 1'b0;
            end
          end
        end
        ST_EVAL: begin
          if (block_sampled) begin
            blocked <= 1'b1; // R5
            state <= ST_IDLE;
          end else begin
            triggered <= 1'b1;
            trigger_count <= trigger_count + 16'h0001; // R17
            event_valid <= mask_triggered[`MASK_ON]; // R15 R16
            event_code <= `EV_TRIG_ON;
            event_time <= trig_time;
            fault_type <= next_type;
            sel_react <= next_react;
            sel_cur <= next_cur;
            if (next_type == `FT_NONE) begin
              state <= ST_IDLE; // R11
            end else begin
              div_start <= 1'b1;
              calc_active <= 1'b1;
              state <= ST_CALC;
            end
          end
        end
        ST_CALC: begin
          if (div_done) begin
            wr_ptr <= (wr_ptr == `REC_LAST) ? 4'h0 : wr_ptr + 4'h1; // R18
            if (rec_count != `REC_DEPTH) begin
              rec_count <= rec_count + 4'h1;
            end
            event_valid <= mask_calc[`MASK_ON]; // R15 R16
            event_code <= `EV_CALC_ON;
            event_time <= time_stamp;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          calc_active <= 1'b0;
          event_valid <= mask_calc[`MASK_OFF]; // R15 R16
          event_code <= `EV_CALC_OFF;
          event_time <= time_stamp;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // fault_locator_trigger

// [include/fault_locator_map.vh]
`ifndef FAULT_LOCATOR_MAP_VH
`define FAULT_LOCATOR_MAP_VH
// Measurement and setting widths
`define MAG_W 16
`define REACT_W 16
`define DIST_W 16
`define TS_W 32
// Base time step of the processing cycle
`define CYCLE_NS 5000000
`define CLK_NS 5
// Default trigger current, units of 0.1 x In
`define TRIG_CUR_DEF 16'h000A
// Default line_a, milliohm per km
`define REACT_KM_DEF 16'h007D
// Record store
`define REC_DEPTH 12
`define REC_PTR_W 4
`define REC_LAST 4'hB
// Fault type codes
`define FT_NONE 3'h0
`define FT_AB 3'h1
`define FT_BC 3'h2
`define FT_CA 3'h3
`define FT_AN 3'h4
`define FT_BN 3'h5
`define FT_CN 3'h6
`define FT_ABC 3'h7
// Fault direction codes
`define DIR_NONE 2'h0
`define DIR_FWD 2'h1
`define DIR_REV 2'h2
// Event codes
`define EV_TRIG_ON 2'h0
`define EV_TRIG_OFF 2'h1
`define EV_CALC_ON 2'h2
`define EV_CALC_OFF 2'h3
// Event mask bit positions
`define MASK_ON 0
`define MASK_OFF 1
// Last of the 32 divider steps
`define DIV_LAST 5'h1F
// Dividend scale, milliohm into distance
`define DIST_SCALE 32'h000003E8
// Synchroniser bit positions above the 32 binary signals
`define SYNC_BLOCK 32
`define SYNC_EARTH 33
`endif

// [logic/distance_divider.v]
`timescale 1ns/1ps
`include "fault_locator_map.vh"
// Sequential restoring divider: quotient = num * 1000 / den (metres from mohm)
module distance_divider (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Request
  input wire start,
  input wire [`REACT_W-1:0] num,
  input wire [`REACT_W-1:0] den,
  // Answer
  output reg busy,
  output reg done,
  output reg [`DIST_W-1:0] quotient
);
  reg [31:0] rem;
  reg [31:0] dvd;
  reg [`REACT_W-1:0] dvs;
  reg [4:0] step;
  wire [31:0] trial;

  assign trial = {rem[30:0], dvd[31]} - {16'h0000, dvs};

  // One quotient bit per clock; zero divisor gives all ones
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= 16'h0000;
      rem <= 32'h00000000;
      dvd <= 32'h00000000;
      dvs <= 16'h0000;
      step <= 5'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        rem <= 32'h00000000;
        dvd <= {16'h0000, num} * `DIST_SCALE;
        dvs <= den;
        step <= 5'h00;
        quotient <= 16'h0000;
      end else if (busy) begin
        if (dvs == 16'h0000) begin
          quotient <= 16'hFFFF;
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          dvd <= {dvd[30:0], 1'b0};
          if (!trial[31]) begin
            rem <= trial;
            quotient <= {quotient[14:0], 1'b1};
          end else begin
            rem <= {rem[30:0], dvd[31]};
            quotient <= {quotient[14:0], 1'b0};
          end
          step <= step + 5'h01;
          if (step == `DIV_LAST) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // distance_divider

// [testbench/fault_locator_trigger_chk.sv]
`timescale 1ns/1ps
`include "fault_locator_map.vh"
// ********
// Checker
// ********
module fault_locator_trigger_chk #(
  parameter [19:0] TICK_LAST = 20'hF423F // Last clock of one tick period
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Watched inputs
  input wire count_clear,
  input wire [1:0] mask_triggered,
  input wire [1:0] mask_calc,
  // Watched outputs
  input wire cycle_tick,
  input wire blocked,
  input wire triggered,
  input wire calc_active,
  input wire [15:0] trigger_count,
  input wire event_valid,
  input wire [1:0] event_code,
  input wire [3:0] rec_count,
  input wire [1:0] rec_dir
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reg [19:0] gap;
  reg seen;
  // Clocks since the last tick; the first tick has no reference, so it is skipped
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap <= 20'h00000;
      seen <= 1'b0;
    end else if (cycle_tick) begin
      gap <= 20'h00000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 20'h00001;
    end
  end
  sequence s_trig_on;
    event_valid && event_code == `EV_TRIG_ON;
  endsequence
  sequence s_calc_on;
    event_valid && event_code == `EV_CALC_ON;
  endsequence
  sequence s_calc_off;
    event_valid && event_code == `EV_CALC_OFF;
  endsequence
  property p_tick_period;
    cycle_tick && seen |-> gap == TICK_LAST;
  endproperty
  property p_after_tick;
    $rose(triggered) || $rose(blocked) |-> $past(cycle_tick, 2);
  endproperty
  property p_trig_event;
    $rose(triggered) && mask_triggered[`MASK_ON] |-> s_trig_on;
  endproperty
  property p_calc_pair;
    s_calc_on ##0 mask_calc[`MASK_OFF] |=> s_calc_off;
  endproperty
  property p_calc_needs_trig;
    s_calc_on |-> triggered && !blocked;
  endproperty
  property p_count_inc;
    $rose(triggered) |-> trigger_count == $past(trigger_count) + 16'h0001;
  endproperty
  property p_clear;
    count_clear && !$past(cycle_tick) |=> trigger_count == 16'h0000;
  endproperty
  property p_block_stop;
    blocked |-> !calc_active && !triggered;
  endproperty
  property p_rec_bound;
    rec_count <= 4'hC;
  endproperty
  property p_no_dir;
    rec_dir == `DIR_NONE;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
  a_after_tick: assert property (p_after_tick) else $error("decision not after tick");
  a_trig_event: assert property (p_trig_event) else $error("no trigger ON event");
  a_calc_pair: assert property (p_calc_pair) else $error("no calc OFF event");
  a_calc_needs_trig: assert property (p_calc_needs_trig) else $error("calc without trigger");
  a_count_inc: assert property (p_count_inc) else $error("count not stepped");
  a_clear: assert property (p_clear) else $error("count not cleared");
  a_block_stop: assert property (p_block_stop) else $error("blocked but active");
  a_rec_bound: assert property (p_rec_bound) else $error("too many records");
  a_no_dir: assert property (p_no_dir) else $error("direction not zero");
endmodule // fault_locator_trigger_chk

bind fault_locator_trigger fault_locator_trigger_chk #(.TICK_LAST(CYCLE_LAST))
  i_fault_locator_trigger_chk (
  .sys_clk, .sys_rst, .count_clear, .mask_triggered, .mask_calc, .cycle_tick, .blocked,
  .triggered, .calc_active, .trigger_count, .event_valid, .event_code, .rec_count, .rec_dir
);

// [testbench/protection_b_source.sv]
`timescale 1ns/1ps
// ******************
// Protection_b and breaker source
// ******************
module protection_b_source (
  // Clock
  input wire sys_clk,
  // Bench commands
  input wire protection_b_cmd,
  input wire block_cmd,
  // Toward the locator
  output reg [31:0] binary_signals = 32'h00000080,
  output reg block_in = 1'b0
);
  // Protection_b on bit 3, breaker open on bit 7; open is the inverse of protection_b, so an
  // unselected bit rises every time the protection_b clears and must be ignored
  always @(posedge sys_clk) begin
    binary_signals <= {24'h000000, ~protection_b_cmd, 3'h0, protection_b_cmd, 3'h0};
    block_in <= block_cmd;
  end
endmodule // protection_b_source

// [testbench/fault_locator_trigger_test.sv]
`timescale 1ns/1ps
`include "fault_locator_map.vh"
module fault_locator_trigger_test;
  // ********
  // Signals
  // ********
  // Tick shortened from 5 ms so the run stays short; behaviour per tick is unchanged
  localparam integer TICK_CLKS = 500;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg protection_b_cmd = 1'b0;
  reg block_cmd = 1'b0;
  reg [15:0] phase_a_current = 16'h000B;
  reg [15:0] phase_b_current = 16'h000B;
  reg [15:0] phase_c_current = 16'h000B;
  reg earth_voltage_valid = 1'b1;
  reg [15:0] nominal_primary_amps = 16'h0064;
  reg [15:0] loop_ab_reactance = 16'h00FA;
  reg [15:0] loop_bc_reactance = 16'h0BB8;
  reg [15:0] loop_ca_reactance = 16'h012C;
  reg [15:0] loop_a_neutral_reactance = 16'h0FA0;
  reg [15:0] loop_b_neutral_reactance = 16'h0190;
  reg [15:0] loop_c_neutral_reactance = 16'h1388;
  reg [2:0] active_group = 3'h0;
  reg [127:0] trigger_current_set = {{6{16'h000A}}, 16'h0014, 16'h000A};
  reg [127:0] line_a_set = {{6{16'h007D}}, 16'h00C8, 16'h007D};
  reg [1:0] mask_triggered = 2'h3;
  reg [1:0] mask_calc = 2'h3;
  reg [31:0] time_stamp = 32'h00000000;
  reg count_clear = 1'b0;
  reg [3:0] rec_index = 4'h0;
  reg [4:0] trigger_select = 5'h03;
  wire [31:0] binary_signals;
  wire block_in, cycle_tick, blocked, triggered, calc_active, event_valid;
  wire [15:0] trigger_count, rec_react, rec_dist, rec_cur_pu;
  wire [1:0] event_code, rec_event, rec_dir;
  wire [31:0] event_time, rec_time, rec_cur_pri;
  wire [3:0] rec_count;
  wire [2:0] rec_type, rec_group;
  integer err_count = 0;
  integer comparisons = 0;
  integer ev_n [0:3];
  reg [31:0] last_ev, tick_ts;
  reg [31:0] ts_rec [0:2];
  reg [15:0] cnt;
  fault_locator_trigger #(.CYCLE_CLKS(TICK_CLKS)) i_fault_locator_trigger (
    .sys_clk, .sys_rst, .binary_signals, .trigger_select, .block_in, .phase_a_current,
    .phase_b_current, .phase_c_current, .earth_voltage_valid, .nominal_primary_amps,
    .loop_ab_reactance, .loop_bc_reactance, .loop_ca_reactance, .loop_a_neutral_reactance,
    .loop_b_neutral_reactance, .loop_c_neutral_reactance, .active_group,
    .trigger_current_set, .line_a_set, .mask_triggered, .mask_calc, .time_stamp,
    .count_clear, .cycle_tick, .blocked, .triggered, .calc_active, .trigger_count,
    .event_valid, .event_code, .event_time, .rec_index, .rec_count, .rec_time, .rec_event,
    .rec_type, .rec_dir, .rec_react, .rec_cur_pu, .rec_cur_pri, .rec_dist, .rec_group
  );
  protection_b_source i_protection_b_source (.sys_clk, .protection_b_cmd, .block_cmd, .binary_signals, .block_in);
  // ********
  // Clock, time base and event monitor
  // ********
  always #2.5 sys_clk = ~sys_clk;
  // Events are tallied per code so masked codes show up as missing counts
  always @(posedge sys_clk) begin
    time_stamp <= time_stamp + 32'h00000001;
    if (event_valid === 1'b1) begin
      ev_n[event_code] <= ev_n[event_code] + 1;
      last_ev <= event_time;
    end
  end
  // ********
  // Tasks
  // ********
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  // Sets the protection_b and block commands, then waits for the next short tick plus 64 clocks of settling
  task step(input t, input b);
    begin
      protection_b_cmd = t;
      block_cmd = b;
      @(posedge sys_clk);
      #1;
      while (cycle_tick !== 1'b1) begin
        @(posedge sys_clk);
        #1;
      end
      tick_ts = time_stamp;
      repeat (64) @(posedge sys_clk);
      #1;
    end
  endtask
  task rd_rec(input [3:0] idx, input [2:0] ty, input [15:0] x, input [15:0] km,
              input [2:0] g, input [15:0] cur, input [31:0] ts);
    begin
      rec_index = idx;
      repeat (2) @(posedge sys_clk);
      #1;
      check(rec_type, ty);
      check(rec_react, x);
      check(rec_dist, (x * 32'd1000) / km);
      check(rec_group, g);
      check(rec_event, `EV_CALC_ON);
      check(rec_dir, `DIR_NONE);
      check(rec_cur_pu, cur);
      check(rec_cur_pri, {16'h0000, cur} * {16'h0000, nominal_primary_amps});
      check(rec_time, ts);
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  // ********
  // Tests
  // ********
  // Each trigger waits for a tick, so the run spans about 31 short ticks
  initial begin
    for (int i = 0; i < 4; i++) ev_n[i] = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    step(1'b1, 1'b0);
    check(triggered, 1'b1);
    ts_rec[0] = tick_ts;
    check(trigger_count, 16'h0001);
    check(rec_count, 4'h1);
    check(ev_n[0] * 256 + ev_n[2] * 16 + ev_n[3], 32'h111);
    check((last_ev - tick_ts) < 32'd64, 1'b1);
    step(1'b0, 1'b0);
    check(triggered, 1'b0);
    check(ev_n[1], 1);
    mask_triggered = 2'h1;
    phase_a_current = 16'h0000;
    phase_c_current = 16'h0000;
    step(1'b1, 1'b0);
    check(rec_count, 4'h2);
    ts_rec[1] = tick_ts;
    step(1'b0, 1'b0);
    check(ev_n[1] * 16 + ev_n[0], 32'h12);
    mask_triggered = 2'h3;
    earth_voltage_valid = 1'b0;
    phase_b_current = 16'h0000;
    phase_c_current = 16'h0020;
    step(1'b1, 1'b0);
    check(rec_count, 4'h2);
    step(1'b0, 1'b0);
    earth_voltage_valid = 1'b1;
    active_group = 3'h1;
    phase_a_current = 16'h0015;
    phase_b_current = 16'h0014;
    phase_c_current = 16'h0015;
    step(1'b1, 1'b0);
    check(rec_count, 4'h3);
    ts_rec[2] = tick_ts;
    step(1'b0, 1'b0);
    rd_rec(4'h0, `FT_ABC, loop_ab_reactance, 16'h007D, 3'h0, 16'h000B, ts_rec[0]);
    rd_rec(4'h1, `FT_BN, loop_b_neutral_reactance, 16'h007D, 3'h0, 16'h000B, ts_rec[1]);
    rd_rec(4'h2, `FT_CA, loop_ca_reactance, 16'h00C8, 3'h1, 16'h0015, ts_rec[2]);
    cnt = trigger_count;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    check(blocked, 1'b1);
    check(trigger_count, cnt);
    check(rec_count, 4'h3);
    step(1'b0, 1'b0);
    check(blocked, 1'b0);
    // Ten more passes overfill the ring, so the very first entry must be gone
    repeat (10) begin
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
    check(rec_count, 4'hC);
    rd_rec(4'h0, `FT_BN, loop_b_neutral_reactance, 16'h007D, 3'h0, 16'h000B, ts_rec[1]);
    rd_rec(4'h1, `FT_CA, loop_ca_reactance, 16'h00C8, 3'h1, 16'h0015, ts_rec[2]);
    count_clear = 1'b1;
    @(posedge sys_clk);
    #1;
    count_clear = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check(trigger_count, 16'h0000);
    end_sim;
  end
  // Watchdog: about 31 ticks are needed, forty is the limit
  initial begin
    repeat (40 * TICK_CLKS) @(posedge sys_clk);
    err_count = err_count + 1;
    end_sim;
  end
endmodule // fault_locator_trigger_test
